// File: include/asp_pkg.sv
// ****************************************************************
// serial port constants
// ****************************************************************
package asp_pkg;

  // apb register map
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam logic [7:0]  ADDR_CONTROL = 8'h00;
  localparam logic [7:0]  ADDR_BUFFER  = 8'h04;

  // serial_control_register field positions
  localparam int          CTL_MODE     = 0;
  localparam int          CTL_MODE_W   = 2;
  localparam int          CTL_MPFE     = 2;
  localparam int          CTL_TNB      = 3;
  localparam int          CTL_FAST     = 4;
  localparam int          CTL_RNB      = 8;
  localparam int          CTL_RDF      = 9;
  localparam int          CTL_TDF      = 10;
  localparam int          BYTE_W       = 8;
  localparam logic [31:0] WORD_ZERO    = 32'h0;

  // operating modes
  localparam logic [1:0]  MODE_0       = 2'h0;
  localparam logic [1:0]  MODE_1       = 2'h1;
  localparam logic [1:0]  MODE_2       = 2'h2;
  localparam logic [1:0]  MODE_3       = 2'h3;

  // divide-by-16 counter and bit detector
  localparam int          CNT_W        = 4;
  localparam logic [3:0]  CNT_ZERO     = 4'h0;
  localparam logic [3:0]  CNT_ONE      = 4'h1;
  localparam logic [3:0]  CNT_LAST     = 4'hF;
  localparam logic [3:0]  SAMPLE_FIRST = 4'h7;
  localparam logic [3:0]  SAMPLE_MID   = 4'h8;
  localparam logic [3:0]  SAMPLE_LAST  = 4'h9;

  // shift registers
  localparam int          SHIFT_W      = 9;
  localparam logic [8:0]  RX_FILL      = 9'h1FF;
  localparam logic [6:0]  TX_ZEROS     = 7'h00;

  typedef enum logic [1:0]
  {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_LEAD  = 2'b10,
    TX_SHIFT = 2'b11
  } asp_tx_state_t;

  typedef enum logic [1:0]
  {
    RX_HUNT = 2'b00,
    RX_BITS = 2'b01,
    RX_STOP = 2'b10
  } asp_rx_state_t;

endpackage

// File: include/asp_sample_if.sv
`timescale 1ns/100ps
// ****************************************************************
// link between port control and bit detector
// ****************************************************************
interface asp_sample_if;
  logic                       os_tick;
  logic                       restart;
  logic [asp_pkg::CNT_W-1:0]  count;
  logic                       rxd;
  logic                       sample_valid;
  logic                       sample_bit;

  modport detector
  (
    input  os_tick,
    input  restart,
    input  count,
    input  rxd,
    output sample_valid,
    output sample_bit
  );

  modport port
  (
    output os_tick,
    output restart,
    output count,
    output rxd,
    input  sample_valid,
    input  sample_bit
  );
endinterface

// File: src/asp_bit_detector.sv
`timescale 1ns/100ps
// ****************************************************************
// three-sample majority bit detector
// ****************************************************************
module asp_bit_detector
(
  // clock and reset
  input  wire logic      i_clock,
  input  wire logic      i_rst,
  // sampling link
  asp_sample_if.detector smp
);
  import asp_pkg::*;

  logic first_sample;
  logic mid_sample;
  logic last_hit;

  assign last_hit = smp.os_tick && (smp.count == SAMPLE_LAST);

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      first_sample <= 1'b1;
      mid_sample   <= 1'b1;
    end
    else if (smp.os_tick && (smp.count == SAMPLE_FIRST))
      first_sample <= smp.rxd;
    else if (smp.os_tick && (smp.count == SAMPLE_MID))
      mid_sample <= smp.rxd;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      smp.sample_valid <= 1'b0;
      smp.sample_bit   <= 1'b1;
    end
    else if (smp.restart)
      smp.sample_valid <= 1'b0;
    else
    begin
      smp.sample_valid <= last_hit;
      if (last_hit)
        smp.sample_bit <= (first_sample & mid_sample) | (first_sample & smp.rxd) | (mid_sample & smp.rxd);
    end
  end
endmodule

// File: src/asp_serial_port.sv
`timescale 1ns/100ps
// ****************************************************************
// Summary of operation
// - mode 1 receiver: 9-bit shift, start at left triggers final shift and load
// - mode 1 load only if receive flag clear and filter off or stop one
// - mode 1 accepted: stop bit to ninth field, data to buffer, flag set
// - mode 1 receiver returns to hunting right after the final shift
// - modes 2/3 frame: start 0, eight data lsb first, ninth, stop 1
// - modes 2/3 send transmit ninth bit; store received ninth bit
// - mode 2 rate clock/16 or clock/32; mode 3 from timer overflow
// - modes 2/3 buffer write loads ninth bit into position nine, requests send
// - transmission starts after next divide-by-16 rollover
// - start bit first, data output one bit later, first shift after that
// - modes 2/3 first shift fills one, later shifts fill zeros
// - modes 2/3 end pattern: last shift, send ends, transmit flag at 11th rollover
// - receiver starts on falling edge sampled at sixteen times bit rate
// - start edge resets divide-by-16 counter and loads all ones
// - samples at states 7, 8, 9 decided by majority of three
// - first bit not zero aborts to hunting, else start bit shifted in
// - modes 2/3 load only if flag clear and filter off or ninth one
// - modes 2/3 accepted: ninth to field, data to buffer; rejected lost
// - modes 2/3 return to hunting one bit time after final shift
// - mode 1 frame: start 0, eight data lsb first, stop 1
// - mode 1 write loads one into position nine; flag at 10th rollover
// - modes 1 and 3 bit rate is timer overflow rate over 16
// ****************************************************************
module asp_serial_port
(
  // clock and reset
  input  wire logic                       i_clock,
  input  wire logic                       i_rst,
  // apb slave
  input  wire logic                       i_psel,
  input  wire logic                       i_penable,
  input  wire logic                       i_pwrite,
  input  wire logic [asp_pkg::ADDR_W-1:0] i_paddr,
  input  wire logic [asp_pkg::DATA_W-1:0] i_pwdata,
  output logic      [asp_pkg::DATA_W-1:0] o_prdata,
  output logic                            o_pready,
  output logic                            o_pslverr,
  // rate source
  input  wire logic                       i_timer_overflow,
  // serial pins
  input  wire logic                       i_rxd,
  output logic                            o_txd
);
  import asp_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [1:0]          mode;
  logic                multiprocessor_filter_enable;
  logic                transmit_ninth_bit;
  logic                fast_rate;
  logic                received_ninth_bit;
  logic                receive_done_flag;
  logic                transmit_done_flag;
  logic [7:0]          serial_buffer;
  logic [DATA_W-1:0]   control_word;

  logic                apb_setup;
  logic                apb_access;
  logic                addr_hit;
  logic                wr_control;
  logic                wr_buffer;

  logic                half_tick;
  logic                os_tick;
  logic [CNT_W-1:0]    div_count;
  logic                rollover;
  logic                rxd_prev;
  logic                start_edge;

  asp_tx_state_t       tx_state;
  logic [SHIFT_W-1:0]  tx_shift;
  logic                tx_pending;
  logic                tx_end_pattern;
  logic                tx_done_set;

  asp_rx_state_t       rx_state;
  logic [SHIFT_W-1:0]  rx_shift;
  logic                rx_final;
  logic                rx_load;
  logic [BYTE_W-1:0]   rx_byte;

  asp_sample_if        smp ();

  // ****************************************************************
  // apb slave, zero wait states
  // ****************************************************************
  assign apb_setup  = i_psel && !i_penable;
  assign apb_access = i_psel && i_penable;
  assign addr_hit   = (i_paddr == ADDR_CONTROL) || (i_paddr == ADDR_BUFFER);
  assign wr_control = apb_access && i_pwrite && (i_paddr == ADDR_CONTROL);
  assign wr_buffer  = apb_access && i_pwrite && (i_paddr == ADDR_BUFFER);
  assign o_pready   = 1'b1;
  assign o_pslverr  = apb_access && !addr_hit;

  always_comb
  begin
    control_word                              = WORD_ZERO;
    control_word[CTL_MODE +: CTL_MODE_W]      = mode;
    control_word[CTL_MPFE]                    = multiprocessor_filter_enable;
    control_word[CTL_TNB]                     = transmit_ninth_bit;
    control_word[CTL_FAST]                    = fast_rate;
    control_word[CTL_RNB]                     = received_ninth_bit;
    control_word[CTL_RDF]                     = receive_done_flag;
    control_word[CTL_TDF]                     = transmit_done_flag;
  end

  // read data captured in the setup cycle, valid through the access cycle
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      o_prdata <= WORD_ZERO;
    else if (apb_setup && !i_pwrite)
    begin
      if (i_paddr == ADDR_CONTROL)
        o_prdata <= control_word;
      else if (i_paddr == ADDR_BUFFER)
        o_prdata <= {{(DATA_W-BYTE_W){1'b0}}, serial_buffer};
      else
        o_prdata <= WORD_ZERO;
    end
  end

  // ****************************************************************
  // control fields
  // ****************************************************************
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      mode                         <= MODE_0;
      multiprocessor_filter_enable <= 1'b0;
      transmit_ninth_bit           <= 1'b0;
      fast_rate                    <= 1'b0;
    end
    else if (wr_control)
    begin
      mode                         <= i_pwdata[CTL_MODE +: CTL_MODE_W];
      multiprocessor_filter_enable <= i_pwdata[CTL_MPFE];
      transmit_ninth_bit           <= i_pwdata[CTL_TNB];
      fast_rate                    <= i_pwdata[CTL_FAST];
    end
  end

  // done flags: a hardware set wins over a software clear
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      receive_done_flag  <= 1'b0;
      transmit_done_flag <= 1'b0;
    end
    else
    begin
      receive_done_flag  <= (wr_control ? i_pwdata[CTL_RDF] : receive_done_flag) | rx_load;
      transmit_done_flag <= (wr_control ? i_pwdata[CTL_TDF] : transmit_done_flag) | tx_done_set;
    end
  end

  // ****************************************************************
  // bit rate and divide-by-16 counter
  // ****************************************************************
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      half_tick <= 1'b0;
    else
      half_tick <= ~half_tick;
  end

  always_comb
  begin
    unique case (mode)
      MODE_0:  os_tick = 1'b0;
      MODE_1:  os_tick = i_timer_overflow;
      MODE_2:  os_tick = fast_rate ? 1'b1 : half_tick;
      MODE_3:  os_tick = i_timer_overflow;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      div_count <= CNT_ZERO;
    else if (start_edge)
      div_count <= CNT_ZERO;
    else if (os_tick)
      div_count <= div_count + CNT_ONE;
  end

  assign rollover = os_tick && (div_count == CNT_LAST);

  // ****************************************************************
  // start edge hunt
  // ****************************************************************
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      rxd_prev <= 1'b1;
    else if (os_tick)
      rxd_prev <= i_rxd;
  end

  assign start_edge = os_tick && (rx_state == RX_HUNT) && rxd_prev && !i_rxd;

  // ****************************************************************
  // bit detector
  // ****************************************************************
  assign smp.os_tick = os_tick;
  assign smp.restart = start_edge;
  assign smp.count   = div_count;
  assign smp.rxd     = i_rxd;

  asp_bit_detector u_detector
  (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .smp     (smp.detector)
  );

  // ****************************************************************
  // receiver
  // ****************************************************************
  // the start bit has reached the left end: this sample is the last shift
  assign rx_final = smp.sample_valid && (rx_state == RX_BITS) && !rx_shift[SHIFT_W-1];
  // stop bit in mode 1, ninth data bit in modes 2 and 3
  assign rx_load  = rx_final && !receive_done_flag &&
                    (!multiprocessor_filter_enable || smp.sample_bit);

  // first data bit sits highest in the shift register: reverse it into the byte
  always_comb
  begin
    for (int b = 0; b < BYTE_W; b++)
      rx_byte[b] = rx_shift[BYTE_W-1-b];
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      rx_state <= RX_HUNT;
      rx_shift <= RX_FILL;
    end
    else
    begin
      unique case (rx_state)
        RX_HUNT:
        begin
          if (start_edge)
          begin
            rx_shift <= RX_FILL;
            rx_state <= RX_BITS;
          end
        end
        RX_BITS:
        begin
          if (smp.sample_valid)
          begin
            if ((rx_shift == RX_FILL) && smp.sample_bit)
              rx_state <= RX_HUNT;
            else
            begin
              rx_shift <= {rx_shift[SHIFT_W-2:0], smp.sample_bit};
              if (rx_final)
                rx_state <= (mode == MODE_1) ? RX_HUNT : RX_STOP;
            end
          end
        end
        RX_STOP:
        begin
          if (smp.sample_valid)
            rx_state <= RX_HUNT;
        end
        default:
          rx_state <= RX_HUNT;
      endcase
    end
  end

  // accepted frame: data to buffer, last bit to the ninth field
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      serial_buffer      <= 8'h00;
      received_ninth_bit <= 1'b0;
    end
    else if (rx_load)
    begin
      serial_buffer      <= rx_byte;
      received_ninth_bit <= smp.sample_bit;
    end
    else if (wr_control)
      received_ninth_bit <= i_pwdata[CTL_RNB];
  end

  // ****************************************************************
  // transmitter
  // ****************************************************************
  // ninth bit (last data bit in mode 1) at the output, stop bit beside it, zeros beyond
  assign tx_end_pattern = (tx_shift[SHIFT_W-1:2] == TX_ZEROS) && tx_shift[1];
  assign tx_done_set    = rollover && !wr_buffer && (tx_state == TX_SHIFT) && tx_end_pattern;

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      tx_state   <= TX_IDLE;
      tx_shift   <= RX_FILL;
      tx_pending <= 1'b0;
      o_txd      <= 1'b1;
    end
    else if (wr_buffer)
    begin
      // mode 1 puts the stop bit in position nine, others the ninth bit
      tx_shift   <= {(mode == MODE_1) ? 1'b1 : transmit_ninth_bit, i_pwdata[BYTE_W-1:0]};
      tx_pending <= 1'b1;
    end
    else if (rollover)
    begin
      unique case (tx_state)
        TX_IDLE:
        begin
          if (tx_pending)
          begin
            tx_pending <= 1'b0;
            tx_state   <= TX_START;
            o_txd      <= 1'b0;
          end
        end
        TX_START:
        begin
          tx_state <= TX_LEAD;
          o_txd    <= tx_shift[0];
        end
        TX_LEAD:
        begin
          // first shift: stop bit enters in modes 2 and 3
          tx_shift <= {(mode != MODE_1), tx_shift[SHIFT_W-1:1]};
          o_txd    <= tx_shift[1];
          tx_state <= TX_SHIFT;
        end
        TX_SHIFT:
        begin
          tx_shift <= {1'b0, tx_shift[SHIFT_W-1:1]};
          if (tx_end_pattern)
          begin
            tx_state <= TX_IDLE;
            o_txd    <= 1'b1;
          end
          else
            o_txd <= tx_shift[1];
        end
      endcase
    end
  end

endmodule

// File: testbench/asp_serial_port_assertions.sv
`timescale 1ns/100ps
// ****************************************************************
// port-level checks of the serial port
// ****************************************************************
module asp_serial_port_assertions
(
  // clock and reset
  input wire logic                       i_clock,
  input wire logic                       i_rst,
  // apb slave
  input wire logic                       i_psel,
  input wire logic                       i_penable,
  input wire logic                       i_pwrite,
  input wire logic [asp_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [asp_pkg::DATA_W-1:0] i_pwdata,
  input wire logic [asp_pkg::DATA_W-1:0] o_prdata,
  input wire logic                       o_pready,
  input wire logic                       o_pslverr,
  // serial output
  input wire logic                       o_txd
);
  import asp_pkg::*;

  logic [1:0] seen_mode;
  logic       seen_fast;
  logic       prev_txd;
  logic [9:0] run_len;
  logic       access;
  logic       mapped;

  assign access = i_psel && i_penable;
  assign mapped = (i_paddr == ADDR_CONTROL) || (i_paddr == ADDR_BUFFER);

  // mode and rate last written by software
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      seen_mode <= MODE_0;
      seen_fast <= 1'b0;
    end
    else if (access && i_pwrite && i_paddr == ADDR_CONTROL)
    begin
      seen_mode <= i_pwdata[CTL_MODE +: CTL_MODE_W];
      seen_fast <= i_pwdata[CTL_FAST];
    end
  end

  // cycles the line has held its level
  always_ff @(posedge i_clock)
  begin
    prev_txd <= o_txd;
    if (i_rst)
      run_len <= 10'h3FF;
    else if (o_txd != prev_txd)
      run_len <= 10'h001;
    else if (run_len != 10'h3FF)
      run_len <= run_len + 10'h001;
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  reset_state_a: assert property ($fell(i_rst) |-> o_txd && o_prdata == WORD_ZERO)
    else $error("port not idle after reset");
  pready_high_a: assert property (access |-> o_pready)
    else $error("access phase not answered at once");
  err_decode_a: assert property (access |-> o_pslverr == !mapped)
    else $error("error response does not match address decode");
  unmapped_read_a: assert property (access && !i_pwrite && !mapped |-> o_prdata == WORD_ZERO)
    else $error("unmapped read returned data");
  buf_upper_a: assert property (access && !i_pwrite && i_paddr == ADDR_BUFFER |-> o_prdata[31:8] == 24'h000000)
    else $error("buffer read upper bits not zero");
  bit_min_a: assert property (o_txd != prev_txd |-> run_len >= 10'h010)
    else $error("serial level held under one bit time");
  mode2_rate_a: assert property (seen_mode == MODE_2 && o_txd && !prev_txd |->
    (seen_fast ? run_len[3:0] == 4'h0 : run_len[4:0] == 5'h00))
    else $error("low span not whole bit times");
  tx_start_a: assert property (access && i_pwrite && i_paddr == ADDR_BUFFER && o_txd |=> o_txd)
    else $error("start bit not aligned to counter rollover");
endmodule

bind asp_serial_port asp_serial_port_assertions chk_u
(
  .i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_txd(o_txd)
);

// File: testbench/asp_remote_serial.sv
`timescale 1ns/100ps
// ****************************************************************
// remote serial transmitter and receiver
// ****************************************************************
module asp_remote_serial
(
  // clock
  input  wire logic i_clock,
  // serial lines
  input  wire logic i_txd,
  output logic      o_rxd
);
  initial o_rxd = 1'b1;

  // one frame of len cycles a bit, optional one-cycle spike in first data bit
  task automatic send(input logic [7:0] data, input logic ninth, input int nbits, input int len,
                      input logic spike);
    logic [10:0] bits;
    bits = {1'b1, ninth, data, 1'b0};
    for (int i = 0; i < nbits; i++)
    begin
      @(posedge i_clock);
      o_rxd <= bits[i];
      if (spike && i == 1)
      begin
        repeat (8) @(posedge i_clock);
        o_rxd <= ~bits[i];
        @(posedge i_clock);
        o_rxd <= bits[i];
        repeat (len - 10) @(posedge i_clock);
      end
      else
        repeat (len - 1) @(posedge i_clock);
    end
    @(posedge i_clock);
    o_rxd <= 1'b1;
    repeat (len) @(posedge i_clock);
  endtask

  // samples each bit of a frame at its middle
  task automatic capture(input int nbits, input int len, output logic [10:0] frame);
    frame = 11'h7FF;
    do
      @(posedge i_clock);
    while (i_txd !== 1'b0);
    repeat (len / 2) @(posedge i_clock);
    frame[0] = i_txd;
    for (int i = 1; i < nbits; i++)
    begin
      repeat (len) @(posedge i_clock);
      frame[i] = i_txd;
    end
  endtask

  // short low pulse that is no start bit
  task automatic glitch(input int width, input int idle);
    @(posedge i_clock);
    o_rxd <= 1'b0;
    repeat (width) @(posedge i_clock);
    o_rxd <= 1'b1;
    repeat (idle) @(posedge i_clock);
  endtask
endmodule

// File: testbench/async_serial_port_modes_1_2_3_tb.sv
`timescale 1ns/100ps
// ****************************************************************
// serial port testbench
// ****************************************************************
module async_serial_port_modes_1_2_3_tb;
  import asp_pkg::*;

  localparam logic [31:0] M1 = 32'(MODE_1) << CTL_MODE;
  localparam logic [31:0] M2 = 32'(MODE_2) << CTL_MODE;
  localparam logic [31:0] M3 = 32'(MODE_3) << CTL_MODE;
  localparam logic [31:0] MPF = 32'h1 << CTL_MPFE;
  localparam logic [31:0] TNB = 32'h1 << CTL_TNB;
  localparam logic [31:0] FST = 32'h1 << CTL_FAST;
  localparam logic [31:0] RNB = 32'h1 << CTL_RNB;
  localparam logic [31:0] RDF = 32'h1 << CTL_RDF;
  localparam logic [31:0] TDF = 32'h1 << CTL_TDF;
  localparam logic [31:0] TX_CTL [5] = '{M2 | FST, M2 | FST | TNB, M2 | TNB, M3, M1};
  localparam logic [7:0]  TX_BYTE [5] = '{8'hA5, 8'h3C, 8'h81, 8'h5A, 8'hC6};
  localparam int          TX_LEN [5] = '{16, 16, 32, 32, 32};
  localparam logic [31:0] RX_CTL [6] = '{M2 | FST | MPF, M2 | FST | MPF | RDF, M2 | FST | MPF, M2 | FST,
                                          M1 | MPF, M1 | MPF};
  localparam logic [7:0]  RX_BYTE [6] = '{8'h96, 8'h55, 8'h33, 8'h33, 8'hC3, 8'hC3};
  localparam logic        RX_NINTH [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
  localparam logic [7:0]  RX_BUF [6] = '{8'h96, 8'h96, 8'h96, 8'h33, 8'h33, 8'hC3};
  localparam logic [31:0] RX_END [6] = '{M2 | FST | MPF | RNB | RDF, M2 | FST | MPF | RDF, M2 | FST | MPF,
                                          M2 | FST | RDF, M1 | MPF, M1 | MPF | RNB | RDF};

  logic              clock = 1'b0;
  logic              rst = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              tovf = 1'b0;
  logic              rxd;
  logic              txd;
  logic [DATA_W-1:0] rd;
  logic              er;
  logic              m1;
  logic [10:0]       frame;
  int                err_total = 0;
  int                samples_checked = 0;

  always #5 clock = ~clock;
  // timer overflow every second cycle
  always @(posedge clock) tovf <= ~tovf;

  asp_serial_port dut_u
  (
    .i_clock(clock), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_timer_overflow(tovf), .i_rxd(rxd), .o_txd(txd)
  );

  asp_remote_serial far_u (.i_clock(clock), .i_txd(txd), .o_rxd(rxd));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clock);
    err_total++;
    $display("[ERR] watchdog expired");
    final_report();
  end

  initial
  begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    apb(1'b1, 8'h0C, 32'hFFFFFFFF);
    chk("wr_slverr", 32'(er), 32'h00000001);
    apb(1'b0, 8'h08, WORD_ZERO);
    chk("rd_slverr", 32'(er), 32'h00000001);
    chk("rd_unmapped", rd, WORD_ZERO);
    apb(1'b0, ADDR_CONTROL, WORD_ZERO);
    chk("control", rd, WORD_ZERO);
    apb(1'b0, ADDR_BUFFER, WORD_ZERO);
    chk("buffer", rd, WORD_ZERO);
    $display("reset test done");
    for (int i = 0; i < 5; i++)
    begin
      m1 = (TX_CTL[i][CTL_MODE +: CTL_MODE_W] == MODE_1);
      apb(1'b1, ADDR_CONTROL, TX_CTL[i]);
      apb(1'b1, ADDR_BUFFER, 32'(TX_BYTE[i]));
      far_u.capture(m1 ? 10 : 11, TX_LEN[i], frame);
      chk("tx_frame", 32'(frame), {21'h0, 1'b1, m1 | TX_CTL[i][CTL_TNB], TX_BYTE[i], 1'b0});
      apb(1'b0, ADDR_CONTROL, WORD_ZERO);
      chk("tx_done", rd, TX_CTL[i] | TDF);
    end
    $display("transmit test done");
    for (int i = 0; i < 6; i++)
    begin
      m1 = (RX_CTL[i][CTL_MODE +: CTL_MODE_W] == MODE_1);
      apb(1'b1, ADDR_CONTROL, RX_CTL[i]);
      far_u.send(RX_BYTE[i], RX_NINTH[i], m1 ? 10 : 11, m1 ? 32 : 16, i == 3);
      apb(1'b0, ADDR_BUFFER, WORD_ZERO);
      chk("rx_buffer", rd, 32'(RX_BUF[i]));
      apb(1'b0, ADDR_CONTROL, WORD_ZERO);
      chk("rx_control", rd, RX_END[i]);
    end
    $display("receive test done");
    apb(1'b1, ADDR_CONTROL, M2 | FST);
    far_u.glitch(4, 200);
    apb(1'b0, ADDR_CONTROL, WORD_ZERO);
    chk("false_start", rd, M2 | FST);
    far_u.send(8'h1E, 1'b1, 11, 16, 1'b0);
    apb(1'b0, ADDR_BUFFER, WORD_ZERO);
    chk("after_false_start", rd, 32'h0000001E);
    $display("false start test done");
    final_report();
  end
endmodule
